//--- pkg/flm_consts.svh
// Constants of the flash address-space map: commands, sizes, bit positions
`ifndef FLM_CONSTS_SVH
`define FLM_CONSTS_SVH

// Legacy commands, address width follows the extended-address mode
`define FLM_CMD_READ 8'h03
`define FLM_CMD_PROGRAM 8'h02
`define FLM_CMD_SECTOR_ERASE 8'h20
`define FLM_CMD_HALF_ERASE 8'h52
`define FLM_CMD_BLOCK_ERASE 8'hd8
`define FLM_CMD_READ_ID 8'h9f
`define FLM_CMD_READ_PARAM 8'h5a
`define FLM_CMD_SEC_READ 8'h48
`define FLM_CMD_SEC_PROGRAM 8'h42
`define FLM_CMD_SEC_ERASE 8'h44
// Dedicated four-byte commands
`define FLM_CMD_READ4 8'h13
`define FLM_CMD_PROGRAM4 8'h12
`define FLM_CMD_SECTOR_ERASE4 8'h21
`define FLM_CMD_HALF_ERASE4 8'h53
`define FLM_CMD_BLOCK_ERASE4 8'hdc
// Mode and housekeeping commands
`define FLM_CMD_ENTER_ADDR32 8'hb7
`define FLM_CMD_EXIT_ADDR32 8'he9
`define FLM_CMD_CLEAR_STATUS 8'h30
`define FLM_CMD_SOFT_RESET 8'h99

// Address widths in bytes
`define FLM_ADDR_BYTES_24 3'h3
`define FLM_ADDR_BYTES_32 3'h4
// Erase unit shifts: sector 4 KB, half block 32 KB, block 64 KB
`define FLM_SECTOR_SHIFT 12
`define FLM_HALF_SHIFT 15
`define FLM_BLOCK_SHIFT 16

// Security space: 1024 bytes, four regions of 256 bytes
`define FLM_SEC_BYTES 1024
`define FLM_SEC_REGIONS 4
`define FLM_SEC_ERASED 8'hff
`define FLM_SEC_UNDEF 8'h00
// Lock bits in config1_nonvolatile
`define FLM_CFG1_LOCK_LSB 2
// Bits of region_protection_reg
`define FLM_IRP_PWD_BIT 2
`define FLM_IRP_READ_BIT 6
// Error bits of status2_volatile
`define FLM_SR2_PERR_BIT 6
`define FLM_SR2_EERR_BIT 5
`define FLM_SR2_RESET 8'h00

// Identification and parameter spaces
`define FLM_ID_BYTES 16
`define FLM_PARAM_HEAD_BYTES 16
`define FLM_PARAM_ID_BASE 32'h00000040
`define FLM_BLANK_BYTE 8'hff

`endif

//--- pkg/flm_pkg.sv
// Types shared by the flash address-space map design
`default_nettype none
package flm_pkg;

	typedef enum logic [2:0] {
		FLM_ST_CMD = 3'b000,
		FLM_ST_ADDR = 3'b001,
		FLM_ST_DUMMY = 3'b010,
		FLM_ST_READ = 3'b011,
		FLM_ST_WRITE = 3'b100,
		FLM_ST_TAIL = 3'b101
	} flm_state_t;

	typedef enum logic [3:0] {
		FLM_OP_NONE = 4'b0000,
		FLM_OP_ARRAY_RD = 4'b0001,
		FLM_OP_ID_RD = 4'b0010,
		FLM_OP_PARAM_RD = 4'b0011,
		FLM_OP_SEC_RD = 4'b0100,
		FLM_OP_ARRAY_PGM = 4'b0101,
		FLM_OP_SEC_PGM = 4'b0110,
		FLM_OP_ARRAY_ERS = 4'b0111,
		FLM_OP_SEC_ERS = 4'b1000,
		FLM_OP_MODE32 = 4'b1001,
		FLM_OP_MODE24 = 4'b1010,
		FLM_OP_CLR_STAT = 4'b1011,
		FLM_OP_SW_RST = 4'b1100
	} flm_op_t;

	typedef enum logic [1:0] {
		FLM_ERS_SECTOR = 2'b00,
		FLM_ERS_HALF = 2'b01,
		FLM_ERS_BLOCK = 2'b10
	} flm_erase_t;

endpackage : flm_pkg
`default_nettype wire

//--- design/flm_link_sync.sv
// Synchroniser and edge finder for the serial link pins
`default_nettype none
module flm_link_sync (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_si,
	output logic o_sck_rise,
	output logic o_sck_fall,
	output logic o_cs_n,
	output logic o_cs_rise,
	output logic o_si
);

	logic [2:0] meta;
	logic [2:0] sync;
	logic sck_prev;
	logic cs_prev;

	// Idle levels: clock low, select high
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta <= 3'b010;
			sync <= 3'b010;
		end else begin
			meta <= {i_si, i_cs_n, i_sck};
			sync <= meta;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sck_prev <= 1'b0;
			cs_prev <= 1'b1;
		end else begin
			sck_prev <= sync[0];
			cs_prev <= sync[1];
		end
	end

	// Data travels through the same depth as the clock, so it stays aligned
	assign o_sck_rise = sync[0] & ~sck_prev;
	assign o_sck_fall = ~sync[0] & sck_prev;
	assign o_cs_n = sync[1];
	assign o_cs_rise = sync[1] & ~cs_prev;
	assign o_si = sync[2];

endmodule : flm_link_sync
`default_nettype wire

//--- design/flm_addr_map.sv
// Address handling, identification spaces and security regions of a flash
`default_nettype none
`include "flm_consts.svh"

module flm_addr_map
	import flm_pkg::*;
#(
	parameter int SEC_BYTES = `FLM_SEC_BYTES,
	// Arbitrary values
	parameter logic [63:0] UNIQUE_ID = 64'h5a3c_9e11_0f27_b4d8,
	parameter logic [63:0] ID_HEAD = 64'h11_22_33_44_55_66_77_88,
	parameter logic [127:0] PARAM_HEAD = 128'h0
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_si,
	output logic o_so,
	output logic o_so_oe,
	input wire logic i_addr32_default_nv,
	input wire logic [7:0] i_config1_nonvolatile,
	input wire logic i_temp_region_lock,
	input wire logic [7:0] i_region_protection_reg,
	input wire logic i_password_ok,
	input wire logic [7:0] i_array_rdata,
	output logic o_addr32_mode,
	output logic [3:0] o_region_locks,
	output logic [31:0] o_array_addr,
	output logic [31-`FLM_SECTOR_SHIFT:0] o_sector_idx,
	output logic [31-`FLM_HALF_SHIFT:0] o_half_block_idx,
	output logic [31-`FLM_BLOCK_SHIFT:0] o_block_idx,
	output logic o_array_rd,
	output logic o_array_pgm,
	output logic [7:0] o_array_wdata,
	output logic o_array_erase,
	output flm_erase_t o_erase_size,
	output logic [7:0] o_status2_volatile
);

	logic sck_rise;
	logic sck_fall;
	logic cs_n;
	logic cs_rise;
	logic si;

	flm_link_sync u_sync (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_sck(i_sck),
		.i_cs_n(i_cs_n),
		.i_si(i_si),
		.o_sck_rise(sck_rise),
		.o_sck_fall(sck_fall),
		.o_cs_n(cs_n),
		.o_cs_rise(cs_rise),
		.o_si(si)
	);

	flm_state_t state;
	flm_op_t op;
	flm_erase_t ers_kind;
	logic [7:0] shreg;
	logic [2:0] bit_cnt;
	logic [2:0] byte_left;
	logic four_byte;
	logic [31:0] addr;
	logic [6:0] out_sh;
	logic [2:0] out_cnt;
	logic init_done;
	logic [7:0] in_byte;
	logic [31:0] eff_addr;
	logic [7:0] rd_byte;
	logic [7:0] sec_mem [SEC_BYTES];
	logic sec_pgm_stb;
	logic [9:0] sec_pgm_idx;
	logic [7:0] sec_pgm_data;
	logic sec_ers_stb;
	logic [1:0] sec_ers_region;
	logic set_perr;
	logic set_eerr;
	logic clr_stat;
	logic sw_rst;
	logic [3:0] wr_blocked;
	logic rd_blocked;
	logic sec_in_range;
	logic [1:0] region;
	logic [31:0] param_off;

	assign in_byte = {shreg[6:0], si};
	// Upper byte forced to zero so 24-bit access stays below 16 MB
	assign eff_addr = four_byte ? addr : {8'h00, addr[23:0]};
	assign region = eff_addr[9:8];
	// Only the low 1 KB of the full address is populated
	assign sec_in_range = (eff_addr < 32'(SEC_BYTES));
	assign param_off = eff_addr - `FLM_PARAM_ID_BASE;

	// Write protection per region
	always_comb begin
		for (int r = 0; r < `FLM_SEC_REGIONS; r++) begin
			wr_blocked[r] = o_region_locks[r];
			if (r >= 2) begin
				wr_blocked[r] = wr_blocked[r] | i_temp_region_lock;
				wr_blocked[r] = wr_blocked[r] |
					(i_region_protection_reg[`FLM_IRP_PWD_BIT] &
					~i_password_ok);
			end
		end
		rd_blocked = (region == 2'h3) &
			i_region_protection_reg[`FLM_IRP_READ_BIT] & ~i_password_ok;
	end

	// Byte served to the host for the current read
	always_comb begin
		rd_byte = `FLM_BLANK_BYTE;
		case (op)
			FLM_OP_ARRAY_RD: rd_byte = i_array_rdata;
			FLM_OP_ID_RD: begin
				if (eff_addr < 32'h8) begin
					rd_byte = ID_HEAD[8 * (7 - int'(eff_addr[2:0])) +: 8];
				end else if (eff_addr < `FLM_ID_BYTES) begin
					rd_byte = UNIQUE_ID[8 * (7 - int'(eff_addr[2:0])) +: 8];
				end
			end
			FLM_OP_PARAM_RD: begin
				if (eff_addr < `FLM_PARAM_HEAD_BYTES) begin
					rd_byte = PARAM_HEAD[8 * (15 - int'(eff_addr[3:0])) +: 8];
				end else if (param_off < 32'h8 && eff_addr >= `FLM_PARAM_ID_BASE) begin
					rd_byte = ID_HEAD[8 * (7 - int'(param_off[2:0])) +: 8];
				end else if (param_off < `FLM_ID_BYTES &&
					eff_addr >= `FLM_PARAM_ID_BASE) begin
					rd_byte = UNIQUE_ID[8 * (7 - int'(param_off[2:0])) +: 8];
				end
			end
			FLM_OP_SEC_RD: begin
				if (sec_in_range) begin
					// Stored data must not leak past the read protection
					rd_byte = rd_blocked ? `FLM_SEC_UNDEF :
						sec_mem[eff_addr[9:0]];
				end
			end
			default: rd_byte = `FLM_BLANK_BYTE;
		endcase
	end

	// Frame sequencer: command, address, dummy, data phases
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= FLM_ST_CMD;
			op <= FLM_OP_NONE;
			ers_kind <= FLM_ERS_SECTOR;
			shreg <= 8'h00;
			bit_cnt <= 3'h0;
			byte_left <= 3'h0;
			four_byte <= 1'b0;
			addr <= 32'h0;
			out_sh <= 7'h00;
			out_cnt <= 3'h0;
			o_so <= 1'b0;
			o_so_oe <= 1'b0;
		end else if (cs_n) begin
			state <= FLM_ST_CMD;
			bit_cnt <= 3'h0;
			o_so_oe <= 1'b0;
		end else if (sck_rise) begin
			shreg <= in_byte;
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				case (state)
					FLM_ST_CMD: begin
						addr <= 32'h0;
						four_byte <= o_addr32_mode;
						byte_left <= o_addr32_mode ? `FLM_ADDR_BYTES_32 :
							`FLM_ADDR_BYTES_24;
						state <= FLM_ST_ADDR;
						ers_kind <= FLM_ERS_SECTOR;
						// Only reads reach the ID and parameter spaces
						case (in_byte)
							`FLM_CMD_READ: op <= FLM_OP_ARRAY_RD;
							`FLM_CMD_PROGRAM: op <= FLM_OP_ARRAY_PGM;
							`FLM_CMD_SECTOR_ERASE: op <= FLM_OP_ARRAY_ERS;
							`FLM_CMD_HALF_ERASE: begin
								op <= FLM_OP_ARRAY_ERS;
								ers_kind <= FLM_ERS_HALF;
							end
							`FLM_CMD_BLOCK_ERASE: begin
								op <= FLM_OP_ARRAY_ERS;
								ers_kind <= FLM_ERS_BLOCK;
							end
							`FLM_CMD_READ_PARAM: op <= FLM_OP_PARAM_RD;
							`FLM_CMD_SEC_READ: op <= FLM_OP_SEC_RD;
							`FLM_CMD_SEC_PROGRAM: op <= FLM_OP_SEC_PGM;
							`FLM_CMD_SEC_ERASE: op <= FLM_OP_SEC_ERS;
							`FLM_CMD_READ4, `FLM_CMD_PROGRAM4,
							`FLM_CMD_SECTOR_ERASE4, `FLM_CMD_HALF_ERASE4,
							`FLM_CMD_BLOCK_ERASE4: begin
								four_byte <= 1'b1;
								byte_left <= `FLM_ADDR_BYTES_32;
								if (in_byte == `FLM_CMD_READ4) begin
									op <= FLM_OP_ARRAY_RD;
								end else if (in_byte == `FLM_CMD_PROGRAM4) begin
									op <= FLM_OP_ARRAY_PGM;
								end else begin
									op <= FLM_OP_ARRAY_ERS;
								end
								if (in_byte == `FLM_CMD_HALF_ERASE4) begin
									ers_kind <= FLM_ERS_HALF;
								end else if (in_byte == `FLM_CMD_BLOCK_ERASE4) begin
									ers_kind <= FLM_ERS_BLOCK;
								end
							end
							`FLM_CMD_READ_ID: begin
								op <= FLM_OP_ID_RD;
								state <= FLM_ST_READ;
								out_cnt <= 3'h0;
							end
							`FLM_CMD_ENTER_ADDR32: begin
								op <= FLM_OP_MODE32;
								state <= FLM_ST_TAIL;
							end
							`FLM_CMD_EXIT_ADDR32: begin
								op <= FLM_OP_MODE24;
								state <= FLM_ST_TAIL;
							end
							`FLM_CMD_CLEAR_STATUS: begin
								op <= FLM_OP_CLR_STAT;
								state <= FLM_ST_TAIL;
							end
							`FLM_CMD_SOFT_RESET: begin
								op <= FLM_OP_SW_RST;
								state <= FLM_ST_TAIL;
							end
							default: begin
								op <= FLM_OP_NONE;
								state <= FLM_ST_TAIL;
							end
						endcase
					end
					FLM_ST_ADDR: begin
						addr <= {addr[23:0], in_byte};
						byte_left <= byte_left - 3'h1;
						if (byte_left == 3'h1) begin
							out_cnt <= 3'h0;
							case (op)
								FLM_OP_ARRAY_RD: state <= FLM_ST_READ;
								FLM_OP_PARAM_RD, FLM_OP_SEC_RD: state <= FLM_ST_DUMMY;
								FLM_OP_ARRAY_PGM, FLM_OP_SEC_PGM: state <= FLM_ST_WRITE;
								default: state <= FLM_ST_TAIL;
							endcase
						end
					end
					FLM_ST_DUMMY: state <= FLM_ST_READ;
					FLM_ST_WRITE: begin
						// Program wraps inside the 256-byte page
						addr[7:0] <= addr[7:0] + 8'h01;
					end
					default: state <= state;
				endcase
			end
		end else if (sck_fall && state == FLM_ST_READ) begin
			o_so_oe <= 1'b1;
			out_cnt <= out_cnt + 3'h1;
			if (out_cnt == 3'h0) begin
				o_so <= rd_byte[7];
				out_sh <= rd_byte[6:0];
				addr <= addr + 32'h1;
			end else begin
				o_so <= out_sh[6];
				out_sh <= {out_sh[5:0], 1'b0};
			end
		end
	end

	// Action strobes; erase and mode changes only on a whole-byte frame end
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sec_pgm_stb <= 1'b0;
			sec_pgm_idx <= 10'h000;
			sec_pgm_data <= 8'h00;
			sec_ers_stb <= 1'b0;
			sec_ers_region <= 2'h0;
			set_perr <= 1'b0;
			set_eerr <= 1'b0;
			clr_stat <= 1'b0;
			sw_rst <= 1'b0;
			o_array_rd <= 1'b0;
			o_array_pgm <= 1'b0;
			o_array_wdata <= 8'h00;
			o_array_erase <= 1'b0;
			o_erase_size <= FLM_ERS_SECTOR;
		end else begin
			sec_pgm_stb <= 1'b0;
			sec_ers_stb <= 1'b0;
			set_perr <= 1'b0;
			set_eerr <= 1'b0;
			clr_stat <= 1'b0;
			sw_rst <= 1'b0;
			o_array_rd <= 1'b0;
			o_array_pgm <= 1'b0;
			o_array_erase <= 1'b0;
			o_array_rd <= !cs_n && sck_fall && state == FLM_ST_READ &&
				out_cnt == 3'h0 && op == FLM_OP_ARRAY_RD;
			if (!cs_n && sck_rise && bit_cnt == 3'h7 && state == FLM_ST_WRITE) begin
				if (op == FLM_OP_ARRAY_PGM) begin
					o_array_pgm <= 1'b1;
					o_array_wdata <= in_byte;
				end else if (!sec_in_range || wr_blocked[region]) begin
					set_perr <= 1'b1;
				end else begin
					sec_pgm_stb <= 1'b1;
					sec_pgm_idx <= eff_addr[9:0];
					sec_pgm_data <= in_byte;
				end
			end
			// Partial final byte voids the command without any error
			if (cs_rise && bit_cnt == 3'h0 && state == FLM_ST_TAIL) begin
				case (op)
					FLM_OP_ARRAY_ERS: begin
						o_array_erase <= 1'b1;
						o_erase_size <= ers_kind;
					end
					FLM_OP_SEC_ERS: begin
						if (!sec_in_range || wr_blocked[region]) begin
							set_eerr <= 1'b1;
						end else begin
							sec_ers_stb <= 1'b1;
							sec_ers_region <= region;
						end
					end
					FLM_OP_CLR_STAT: clr_stat <= 1'b1;
					FLM_OP_SW_RST: sw_rst <= 1'b1;
					default: clr_stat <= 1'b0;
				endcase
			end
		end
	end

	// Array address and erase-unit indexes, truncating division by shifts
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_array_addr <= 32'h0;
			o_sector_idx <= '0;
			o_half_block_idx <= '0;
			o_block_idx <= '0;
		end else begin
			o_array_addr <= eff_addr;
			o_sector_idx <= eff_addr[31:`FLM_SECTOR_SHIFT];
			o_half_block_idx <= eff_addr[31:`FLM_HALF_SHIFT];
			o_block_idx <= eff_addr[31:`FLM_BLOCK_SHIFT];
		end
	end

	// Volatile copies of non-volatile defaults, caught after reset release
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			init_done <= 1'b0;
			o_addr32_mode <= 1'b0;
			o_region_locks <= 4'h0;
		end else if (!init_done || sw_rst) begin
			init_done <= 1'b1;
			o_addr32_mode <= i_addr32_default_nv;
			o_region_locks <= i_config1_nonvolatile[`FLM_CFG1_LOCK_LSB +: 4];
		end else begin
			// One-time bits: once set they clear only on reset or when a soft reset reloads them from config1
			o_region_locks <= o_region_locks |
				i_config1_nonvolatile[`FLM_CFG1_LOCK_LSB +: 4];
			if (cs_rise && bit_cnt == 3'h0 && op == FLM_OP_MODE32 &&
				state == FLM_ST_TAIL) begin
				o_addr32_mode <= 1'b1;
			end else if (cs_rise && bit_cnt == 3'h0 && op == FLM_OP_MODE24 &&
				state == FLM_ST_TAIL) begin
				o_addr32_mode <= 1'b0;
			end
		end
	end

	// Error flags: a new failure wins over a clear in the same cycle
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_status2_volatile <= `FLM_SR2_RESET;
		end else begin
			o_status2_volatile[`FLM_SR2_PERR_BIT] <= set_perr |
				(o_status2_volatile[`FLM_SR2_PERR_BIT] & ~clr_stat);
			o_status2_volatile[`FLM_SR2_EERR_BIT] <= set_eerr |
				(o_status2_volatile[`FLM_SR2_EERR_BIT] & ~clr_stat);
		end
	end

	// Security storage, one byte per entry
	for (genvar i = 0; i < SEC_BYTES; i++) begin : g_sec
		always_ff @(posedge i_mclk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				sec_mem[i] <= `FLM_SEC_ERASED;
			end else if (sec_ers_stb && sec_ers_region == 2'(i / 256)) begin
				sec_mem[i] <= `FLM_SEC_ERASED;
			end else if (sec_pgm_stb && sec_pgm_idx == 10'(i)) begin
				// Programming can only pull bits low
				sec_mem[i] <= sec_mem[i] & sec_pgm_data;
			end
		end
	end

endmodule : flm_addr_map
`default_nettype wire

//--- tb/flm_addr_map_sva.sv
// Port checker of the flash address-space map, bound to its top
`default_nettype none
module flm_addr_map_chk (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_cs_n,
	input wire logic i_addr32_default_nv,
	input wire logic [7:0] i_config1_nonvolatile,
	input wire logic o_so_oe,
	input wire logic o_addr32_mode,
	input wire logic [3:0] o_region_locks,
	input wire logic [31:0] o_array_addr,
	input wire logic [19:0] o_sector_idx,
	input wire logic [16:0] o_half_block_idx,
	input wire logic [15:0] o_block_idx,
	input wire logic o_array_pgm,
	input wire logic o_array_erase,
	input wire logic [7:0] o_status2_volatile
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	property p_mode_copy;
		$rose(i_reset_n) |=> o_addr32_mode == $past(i_addr32_default_nv);
	endproperty
	a_mode_copy: assert property (p_mode_copy)
		else $error("address mode not loaded from default");
	property p_lock_copy;
		$rose(i_reset_n) |=> o_region_locks == $past(i_config1_nonvolatile[5:2]);
	endproperty
	a_lock_copy: assert property (p_lock_copy)
		else $error("lock bits not copied at reset");
	property p_lock_keep;
		(~o_region_locks & $past(o_region_locks)) == 4'h0;
	endproperty
	a_lock_keep: assert property (p_lock_keep)
		else $error("a set lock bit was cleared");
	// Index is registered in the same cycle as the address; still wait for the address to settle
	property p_unit_idx;
		$stable(o_array_addr) [*3] |-> o_sector_idx == o_array_addr[31:12]
			&& o_half_block_idx == o_array_addr[31:15]
			&& o_block_idx == o_array_addr[31:16];
	endproperty
	a_unit_idx: assert property (p_unit_idx)
		else $error("erase unit index does not match address");
	property p_ers_pulse;
		o_array_erase |-> i_cs_n ##1 !o_array_erase;
	endproperty
	a_ers_pulse: assert property (p_ers_pulse)
		else $error("erase pulse outside frame end");
	property p_oe_off;
		i_cs_n [*8] |-> !o_so_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("data out driven while deselected");
	property p_pgm_quiet;
		o_array_pgm |-> !o_so_oe && !o_array_erase;
	endproperty
	a_pgm_quiet: assert property (p_pgm_quiet)
		else $error("program byte during read or erase");
	property p_st_bits;
		(o_status2_volatile & 8'h9f) == 8'h00;
	endproperty
	a_st_bits: assert property (p_st_bits)
		else $error("unused status bit set");
	property p_eerr_set;
		$rose(o_status2_volatile[5]) |-> $past(i_cs_n, 2);
	endproperty
	a_eerr_set: assert property (p_eerr_set)
		else $error("erase error raised inside a frame");
	property p_err_clear;
		$fell(o_status2_volatile[6]) |-> $past(i_cs_n, 2);
	endproperty
	a_err_clear: assert property (p_err_clear)
		else $error("program error cleared inside a frame");
endmodule : flm_addr_map_chk

bind flm_addr_map flm_addr_map_chk i_flm_addr_map_chk (
	.i_mclk, .i_reset_n, .i_cs_n, .i_addr32_default_nv,
	.i_config1_nonvolatile, .o_so_oe, .o_addr32_mode, .o_region_locks,
	.o_array_addr, .o_sector_idx, .o_half_block_idx, .o_block_idx,
	.o_array_pgm, .o_array_erase, .o_status2_volatile
);
`default_nettype wire

//--- tb/flm_host.sv
// Host link controller model: mode 0 frames, MSB first
`default_nettype none
module flm_host (
	input wire logic i_mclk,
	input wire logic i_so,
	output logic o_sck,
	output logic o_cs_n,
	output logic o_si
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] txb [0:23];
	logic [7:0] rxb [0:15];
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end
	// Half of the 160 ns link period
	task automatic half;
		repeat (20) @(posedge i_mclk);
	endtask : half
	// Clock idles low between frames; unused data line keeps toggling
	task automatic frame(input int ntx, input int nrd);
		int i;
		int r;
		@(posedge i_mclk);
		o_cs_n <= 1'b0;
		for (i = 0; i < 8 * (ntx + nrd); i++) begin
			r = i - 8 * ntx;
			o_si <= (r < 0) ? txb[i / 8][7 - i % 8] : ~o_si;
			half;
			o_sck <= 1'b1;
			if (r >= 0)
				rxb[r / 8][7 - r % 8] <= i_so;
			half;
			o_sck <= 1'b0;
		end
		half;
		o_cs_n <= 1'b1;
		o_si <= ~o_si;
	endtask : frame
endmodule : flm_host
`default_nettype wire

//--- tb/test_flm_addr_map.sv
// Self-checking bench of the flash address-space map
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	n_mismatch++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module test_flm_addr_map
	import flm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Arbitrary identification values
	localparam logic [63:0] UID = 64'h0f1e_2d3c_4b5a_6978;
	localparam logic [63:0] IDH = 64'ha1b2_c3d4_e5f6_0718;
	logic i_mclk, i_reset_n, i_sck, i_cs_n, i_si, o_so, o_so_oe;
	logic i_addr32_default_nv, i_temp_region_lock, i_password_ok;
	logic o_addr32_mode, o_array_rd, o_array_pgm, o_array_erase;
	logic [7:0] i_config1_nonvolatile, i_region_protection_reg;
	logic [7:0] i_array_rdata, o_array_wdata, o_status2_volatile, pgm_d;
	logic [3:0] o_region_locks;
	logic [31:0] o_array_addr;
	logic [19:0] o_sector_idx;
	logic [16:0] o_half_block_idx;
	logic [15:0] o_block_idx;
	flm_erase_t o_erase_size;
	int checks, n_mismatch, n_ers, n_rd, k;
	logic [31:0] rd_first;
	logic so_line;
	logic [7:0] ec [0:5] = '{8'h20, 8'h52, 8'hd8, 8'h21, 8'h53, 8'hdc};
	flm_erase_t es [0:2] = '{FLM_ERS_SECTOR, FLM_ERS_HALF, FLM_ERS_BLOCK};

	flm_addr_map #(.UNIQUE_ID(UID), .ID_HEAD(IDH)) i_flm_addr_map (
		.i_mclk, .i_reset_n, .i_sck, .i_cs_n, .i_si, .o_so, .o_so_oe,
		.i_addr32_default_nv, .i_config1_nonvolatile, .i_temp_region_lock,
		.i_region_protection_reg, .i_password_ok, .i_array_rdata,
		.o_addr32_mode, .o_region_locks, .o_array_addr, .o_sector_idx,
		.o_half_block_idx, .o_block_idx, .o_array_rd, .o_array_pgm,
		.o_array_wdata, .o_array_erase, .o_erase_size, .o_status2_volatile
	);
	// Pulled up while undriven, so a late enable shows as FFh
	assign so_line = o_so_oe ? o_so : 1'b1;
	flm_host i_flm_host (.i_mclk, .i_so(so_line), .o_sck(i_sck),
		.o_cs_n(i_cs_n), .o_si(i_si));
	// Array content is a pattern of its address
	assign i_array_rdata = o_array_addr[7:0] ^ 8'h3c;
	always @(posedge i_mclk) begin
		if (o_array_erase)
			n_ers <= n_ers + 1;
		if (o_array_pgm)
			pgm_d <= o_array_wdata;
		if (o_array_rd && n_rd == 0)
			rd_first <= o_array_addr;
		if (o_array_rd)
			n_rd <= n_rd + 1;
	end
	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task automatic op(input logic [7:0] c, input logic [31:0] a,
		input int na, input logic [7:0] d, input int nd, input int nrd);
		int j;
		i_flm_host.txb[0] = c;
		for (j = 0; j < na; j++)
			i_flm_host.txb[1 + j] = a[8 * (na - 1 - j) +: 8];
		for (j = 0; j < nd; j++)
			i_flm_host.txb[1 + na + j] = d;
		i_flm_host.frame(1 + na + nd, nrd);
		for (j = 0; j < 10 && o_so_oe !== 1'b0; j++)
			@(posedge i_mclk);
		if (j == 10) begin
			n_mismatch++;
			finish_test;
		end
		repeat (6) @(posedge i_mclk);
	endtask : op
	task automatic sread(input logic [31:0] a, input logic [7:0] ex);
		op(8'h48, a, 3, 8'h00, 1, 1);
		`CHK("security byte", ex, i_flm_host.rxb[0])
	endtask : sread

	initial begin
		i_reset_n = 1'b0;
		i_addr32_default_nv = 1'b0;
		i_config1_nonvolatile = 8'h04;
		i_temp_region_lock = 1'b0;
		i_region_protection_reg = 8'h00;
		i_password_ok = 1'b0;
		repeat (4) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		repeat (4) @(posedge i_mclk);
		`CHK("mode", 1'b0, o_addr32_mode)
		`CHK("locks", 4'h1, o_region_locks)
		op(8'h03, 32'h0012_34ff, 3, 8'h00, 0, 2);
		`CHK("rd0", 8'hc3, i_flm_host.rxb[0])
		`CHK("rd1", 8'h3c, i_flm_host.rxb[1])
		`CHK("upper", 8'h00, o_array_addr[31:24])
		`CHK("rd addr", 32'h0012_34ff, rd_first)
		op(8'h13, 32'h01ab_cd10, 4, 8'h00, 0, 1);
		`CHK("rd4", 8'h2c, i_flm_host.rxb[0])
		`CHK("upper4", 8'h01, o_array_addr[31:24])
		op(8'hb7, 32'h0, 0, 8'h00, 0, 0);
		op(8'h03, 32'h0200_0020, 4, 8'h00, 0, 1);
		`CHK("rd32", 8'h1c, i_flm_host.rxb[0])
		op(8'he9, 32'h0, 0, 8'h00, 0, 0);
		`CHK("mode24", 1'b0, o_addr32_mode)
		$display("test addressing done");
		op(8'h02, 32'h00ab_cdef, 3, 8'h96, 1, 0);
		`CHK("wdata", 8'h96, pgm_d)
		`CHK("sector", 20'h00abc, o_sector_idx)
		`CHK("half", 17'h00157, o_half_block_idx)
		`CHK("block", 16'h00ab, o_block_idx)
		for (k = 0; k < 6; k++) begin
			op(ec[k], 32'h0001_8000, k < 3 ? 3 : 4, 8'h00, 0, 0);
			`CHK("erase count", k + 1, n_ers)
			`CHK("erase size", es[k % 3], o_erase_size)
		end
		$display("test array units done");
		op(8'h9f, 32'h0, 0, 8'h00, 0, 16);
		for (k = 0; k < 8; k++) begin
			`CHK("id head", IDH[63 - 8 * k -: 8], i_flm_host.rxb[k])
			`CHK("serial", UID[63 - 8 * k -: 8], i_flm_host.rxb[k + 8])
		end
		op(8'h5a, 32'h0000_0048, 3, 8'h00, 1, 8);
		for (k = 0; k < 8; k++)
			`CHK("param", UID[63 - 8 * k -: 8], i_flm_host.rxb[k])
		$display("test identification done");
		sread(32'h0000_00ff, 8'hff);
		op(8'h42, 32'h0000_0105, 3, 8'h5a, 1, 0);
		op(8'h42, 32'h0000_0205, 3, 8'h77, 1, 0);
		sread(32'h0000_0105, 8'h5a);
		op(8'h44, 32'h0000_0100, 3, 8'h00, 0, 0);
		sread(32'h0000_0105, 8'hff);
		sread(32'h0000_0205, 8'h77);
		op(8'h42, 32'h0000_0010, 3, 8'h33, 1, 0);
		`CHK("lock err", 8'h40, o_status2_volatile)
		sread(32'h0000_0010, 8'hff);
		op(8'h30, 32'h0, 0, 8'h00, 0, 0);
		i_temp_region_lock <= 1'b1;
		op(8'h44, 32'h0000_0300, 3, 8'h00, 0, 0);
		`CHK("temp erase", 8'h20, o_status2_volatile)
		op(8'h42, 32'h0000_0210, 3, 8'h33, 1, 0);
		`CHK("temp pgm", 8'h60, o_status2_volatile)
		i_temp_region_lock <= 1'b0;
		op(8'h30, 32'h0, 0, 8'h00, 0, 0);
		`CHK("cleared", 8'h00, o_status2_volatile)
		i_region_protection_reg <= 8'h04;
		op(8'h42, 32'h0000_0210, 3, 8'ha5, 1, 0);
		`CHK("pwd err", 8'h40, o_status2_volatile)
		op(8'h30, 32'h0, 0, 8'h00, 0, 0);
		i_password_ok <= 1'b1;
		op(8'h42, 32'h0000_0210, 3, 8'ha5, 1, 0);
		sread(32'h0000_0210, 8'ha5);
		`CHK("pwd ok", 8'h00, o_status2_volatile)
		i_region_protection_reg <= 8'h44;
		i_password_ok <= 1'b0;
		op(8'h42, 32'h0000_0310, 3, 8'h11, 1, 0);
		`CHK("pwd err3", 8'h40, o_status2_volatile)
		sread(32'h0000_0300, 8'h00);
		i_password_ok <= 1'b1;
		sread(32'h0000_0310, 8'hff);
		$display("test security regions done");
		i_reset_n <= 1'b0;
		i_addr32_default_nv <= 1'b1;
		repeat (4) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		repeat (4) @(posedge i_mclk);
		`CHK("mode nv", 1'b1, o_addr32_mode)
		`CHK("status rst", 8'h00, o_status2_volatile)
		op(8'h03, 32'h0300_0041, 4, 8'h00, 0, 1);
		`CHK("rd nv", 8'h7d, i_flm_host.rxb[0])
		i_addr32_default_nv <= 1'b0;
		op(8'h99, 32'h0, 0, 8'h00, 0, 0);
		`CHK("mode soft", 1'b0, o_addr32_mode)
		$display("test second reset done");
		finish_test;
	end
endmodule : test_flm_addr_map
`default_nettype wire
